// File: logic/aoirq_ovc_retry.sv
// Per-channel automatic overcurrent power-down and retry sequencer.
`timescale 1ns/1ps
module aoirq_ovc_retry #(
   parameter int RETRY_PERIOD_CYC = aoirq_pkg::RETRY_PERIOD_CYC,
   parameter int RETRY_ON_CYC     = aoirq_pkg::RETRY_ON_CYC
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic auto_mode,
   input  wire logic fault,
   input  wire logic host_restart,
   output logic      amp_on
);
   typedef enum logic [1:0] {S_ON, S_OFF, S_TRY, S_HOLD} aoirq_ovc_state_t;
   aoirq_ovc_state_t state_q, state_d;
   logic [31:0]      cnt_q, cnt_d;

   // Next state: off after a fault, powered briefly at each retry slot.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q + 32'h1;
      unique case (state_q)
         S_ON: begin
            cnt_d = 32'h0;
            if (fault) begin
               state_d = auto_mode ? S_OFF : S_HOLD;
            end
         end
         S_OFF: begin
            if (cnt_q >= 32'(RETRY_PERIOD_CYC - 1)) begin // [RULE_16]
               state_d = S_TRY;
               cnt_d   = 32'h0;
            end
         end
         S_TRY: begin
            if (cnt_q >= 32'(RETRY_ON_CYC - 1)) begin // [RULE_16]
               cnt_d   = 32'h0;
               state_d = fault ? S_OFF : S_ON;
            end
         end
         S_HOLD: begin
            cnt_d = 32'h0;
            if (host_restart) begin
               state_d = S_ON;
            end
         end
      endcase
   end

   // State registers.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= S_ON;
         cnt_q   <= 32'h0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   assign amp_on = (state_q == S_ON) || (state_q == S_TRY); // [RULE_16]
endmodule : aoirq_ovc_retry

// File: logic/aoirq_pkg.sv
// Package with register map, field layout, reset values and timing constants.
package aoirq_pkg;
   localparam logic [3:0]  ADDR_STATUS      = 4'h1;
   localparam logic [3:0]  ADDR_IRQ_ENABLE  = 4'h2;
   localparam logic [3:0]  ADDR_CONFIG      = 4'h3;
   localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0000;
   localparam logic [15:0] IRQ_ENABLE_WMASK = 16'hFF1F;
   localparam logic [15:0] CONFIG_RESET     = 16'h0001;
   localparam logic [15:0] CONFIG_WMASK     = 16'hFDFF;
   localparam logic [15:0] STATUS_RESET     = 16'h0000;
   localparam logic [15:0] STATUS_COR_MASK  = 16'hF027;
   localparam int          COMP_LSB         = 12;
   localparam int          OVC_LSB          = 8;
   localparam int          THSHDN_BIT       = 5;
   localparam int          THWRNG_BIT       = 4;
   localparam int          HVDD_BIT         = 3;
   localparam int          TMOUT_BIT        = 2;
   localparam int          GPIO_BIT         = 1;
   localparam int          CRC_BIT          = 0;
   localparam int          LATCH_LSB        = 12;
   localparam int          CMP_MODE_LSB     = 10;
   localparam int          REF_SEL_BIT      = 8;
   localparam int          TMO_SEL_LSB      = 4;
   localparam int          TMO_RST_BIT      = 3;
   localparam int          TMO_EN_BIT       = 2;
   localparam int          OVC_RESP_BIT     = 1;
   localparam int          CRC_EN_BIT       = 0;
   localparam int          FRAME_BITS_CRC   = 32;
   localparam int          FRAME_BITS_PLAIN = 24;
   localparam logic [1:0]  CMP_OFF          = 2'h0;
   localparam logic [1:0]  CMP_RISE         = 2'h1;
   localparam logic [1:0]  CMP_FALL         = 2'h2;
   localparam logic [1:0]  CMP_LIVE         = 2'h3;
   localparam int          CLK_MHZ          = 125;
   localparam int          TMO_STEP_US      = 100000;
   localparam int          RETRY_PERIOD_US  = 8000;
   localparam int          RETRY_ON_US      = 400;
   localparam int          TMO_STEP_CYC     = TMO_STEP_US * CLK_MHZ;
   localparam int          RETRY_PERIOD_CYC = RETRY_PERIOD_US * CLK_MHZ;
   localparam int          RETRY_ON_CYC     = RETRY_ON_US * CLK_MHZ;
endpackage : aoirq_pkg

// File: logic/aoirq_top.sv
// Interrupt status, enable and configuration registers of the output device.
// Notes on behaviour
// [RULE_01] GPIO edge sets bit 1, read clears.
// [RULE_02] CRC failure sets bit 0, read clears.
// [RULE_03] Enable bits 15:12 gate comparator flags.
// [RULE_04] Enable bits 11:8 gate overcurrent flags.
// [RULE_05] Enable bit 4 gates thermal warning.
// [RULE_06] Enable bit 3 gates supply-low flag.
// [RULE_07] Enable bit 2 gates link time-out.
// [RULE_08] Enable bit 1 gates GPIO edge.
// [RULE_09] Enable bit 0 gates CRC error.
// [RULE_10] Latch bit 0: update only on load.
// [RULE_11] Latch bit 1: data passes straight through.
// [RULE_12] Bits 11:10 select comparator reporting mode.
// [RULE_13] Bit 8 picks internal or external reference.
// [RULE_14] CRC enable selects 32-bit, else 24-bit frames.
// [RULE_15] Time-out period is (code+1) times 100ms.
// [RULE_16] Auto overcurrent retries 400us every 8ms; the sequencer stays off 8ms before each 400us try, so tries recur every 8.4ms.
// [RULE_17] Time-out monitor runs only when enabled.
// [RULE_18] Pin low while any enabled flag set.
// [RULE_19] Event during clearing read keeps flag.
// [RULE_20] Reserved bits read zero, ignore writes.
`timescale 1ns/1ps
module aoirq_top #(
   parameter int TMO_STEP_CYC     = aoirq_pkg::TMO_STEP_CYC,
   parameter int RETRY_PERIOD_CYC = aoirq_pkg::RETRY_PERIOD_CYC,
   parameter int RETRY_ON_CYC     = aoirq_pkg::RETRY_ON_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire logic        frame_done,
   input  wire logic        frame_crc_bad,
   input  wire logic        gpio_edge,
   input  wire logic [3:0]  comparator_out,
   input  wire logic [3:0]  overcurrent_det,
   input  wire logic        thermal_shutdown_det,
   input  wire logic        thermal_warning_det,
   input  wire logic        hv_supply_low_det,
   input  wire logic [3:0]  latch_load_trigger,
   input  wire logic        load_pin_n,
   input  wire logic [3:0]  data_write,
   output logic      [3:0]  dac_update,
   output logic             comparators_on,
   output logic             ext_ref_sel,
   output logic      [5:0]  frame_bits,
   output logic      [3:0]  amp_on,
   output logic             soft_reset_req,
   output logic             int_n
);
   logic [15:0] ien_q, ien_d;
   logic [15:0] cfg_q, cfg_d;
   logic [15:0] sts_q, sts_d;
   logic [3:0]  cmp_q, cmp_d;
   logic [31:0] tmo_cnt_q, tmo_cnt_d;
   logic [3:0]  dac_upd_q, dac_upd_d;
   logic [15:0] events;
   logic [15:0] rd_clear;
   logic        tmo_event;
   logic [1:0]  cmp_mode;
   logic        ien_wr, cfg_wr, sts_rd;

   // Masked register write helper, keeps reserved bits at zero.
   function automatic logic [15:0] masked_write(input logic [15:0] old_v,
                                                input logic [15:0] new_v,
                                                input logic [15:0] mask);
      masked_write = (old_v & ~mask) | (new_v & mask);
   endfunction : masked_write

   assign ien_wr   = reg_wr && (reg_addr == aoirq_pkg::ADDR_IRQ_ENABLE);
   assign cfg_wr   = reg_wr && (reg_addr == aoirq_pkg::ADDR_CONFIG);
   assign sts_rd   = reg_rd && (reg_addr == aoirq_pkg::ADDR_STATUS);
   assign cmp_mode = cfg_q[aoirq_pkg::CMP_MODE_LSB +: 2];

   // Enable and configuration register next values.
   always_comb begin
      ien_d = ien_q;
      cfg_d = cfg_q;
      if (ien_wr) begin
         ien_d = masked_write(ien_q, reg_wdata,
                              aoirq_pkg::IRQ_ENABLE_WMASK); // [RULE_20]
      end
      if (cfg_wr) begin
         cfg_d = masked_write(cfg_q, reg_wdata,
                              aoirq_pkg::CONFIG_WMASK); // [RULE_20]
      end
   end

   // Link time-out counter, restarted by every completed frame, whether its checksum is good or bad.
   always_comb begin
      tmo_cnt_d = tmo_cnt_q + 32'h1;
      tmo_event = 1'b0;
      if (!cfg_q[aoirq_pkg::TMO_EN_BIT] || frame_done) begin // [RULE_17]
         tmo_cnt_d = 32'h0;
      end else if (tmo_cnt_q >= 32'(TMO_STEP_CYC) *
                   (32'(cfg_q[aoirq_pkg::TMO_SEL_LSB +: 4]) + 32'h1)
                   - 32'h1) begin // [RULE_15]
         tmo_cnt_d = 32'h0;
         tmo_event = 1'b1;
      end
   end

   // Comparator event capture per reporting mode.
   always_comb begin
      cmp_d = comparator_out;
      events = 16'h0000;
      unique case (cmp_mode) // [RULE_12]
         aoirq_pkg::CMP_OFF:  events[aoirq_pkg::COMP_LSB +: 4] = 4'h0;
         aoirq_pkg::CMP_RISE: events[aoirq_pkg::COMP_LSB +: 4] =
                                 comparator_out & ~cmp_q;
         aoirq_pkg::CMP_FALL: events[aoirq_pkg::COMP_LSB +: 4] =
                                 ~comparator_out & cmp_q;
         aoirq_pkg::CMP_LIVE: events[aoirq_pkg::COMP_LSB +: 4] = 4'h0;
      endcase
      events[aoirq_pkg::OVC_LSB +: 4]    = overcurrent_det;
      events[aoirq_pkg::THSHDN_BIT]      = thermal_shutdown_det;
      events[aoirq_pkg::TMOUT_BIT]       = tmo_event;
      events[aoirq_pkg::GPIO_BIT]        = gpio_edge; // [RULE_01]
      events[aoirq_pkg::CRC_BIT]         = frame_crc_bad && // [RULE_02]
                                           cfg_q[aoirq_pkg::CRC_EN_BIT];
   end

   // Status flags: sticky bits clear on read, level bits follow condition.
   always_comb begin
      rd_clear = sts_rd ? (sts_q & aoirq_pkg::STATUS_COR_MASK) : 16'h0000;
      if (!cfg_q[aoirq_pkg::OVC_RESP_BIT]) begin
         rd_clear[aoirq_pkg::OVC_LSB +: 4] = 4'h0;
      end else if (sts_rd) begin
         rd_clear[aoirq_pkg::OVC_LSB +: 4] = sts_q[aoirq_pkg::OVC_LSB +: 4];
      end
      sts_d = (sts_q & ~rd_clear) | events; // [RULE_19]
      if (!cfg_q[aoirq_pkg::OVC_RESP_BIT]) begin
         sts_d[aoirq_pkg::OVC_LSB +: 4] = overcurrent_det;
      end
      if (cmp_mode == aoirq_pkg::CMP_LIVE) begin
         sts_d[aoirq_pkg::COMP_LSB +: 4] = comparator_out;
      end
      sts_d[aoirq_pkg::THWRNG_BIT] = thermal_warning_det;
      sts_d[aoirq_pkg::HVDD_BIT]   = hv_supply_low_det;
   end

   // Per-channel DAC latch update strobes.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (cfg_q[aoirq_pkg::LATCH_LSB + i]) begin
            dac_upd_d[i] = data_write[i]; // [RULE_11]
         end else begin
            dac_upd_d[i] = latch_load_trigger[i] || !load_pin_n; // [RULE_10]
         end
      end
   end

   // Register stage for all groups of state.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ien_q     <= aoirq_pkg::IRQ_ENABLE_RESET;
         cfg_q     <= aoirq_pkg::CONFIG_RESET;
         sts_q     <= aoirq_pkg::STATUS_RESET;
         cmp_q     <= 4'h0;
         tmo_cnt_q <= 32'h0;
         dac_upd_q <= 4'h0;
      end else begin
         ien_q     <= ien_d;
         cfg_q     <= cfg_d;
         sts_q     <= sts_d;
         cmp_q     <= cmp_d;
         tmo_cnt_q <= tmo_cnt_d;
         dac_upd_q <= dac_upd_d;
      end
   end

   // Read data mux, unmapped addresses return zero.
   always_comb begin
      unique case (reg_addr)
         aoirq_pkg::ADDR_STATUS:     reg_rdata = sts_q;
         aoirq_pkg::ADDR_IRQ_ENABLE: reg_rdata = ien_q; // [RULE_20]
         aoirq_pkg::ADDR_CONFIG:     reg_rdata = cfg_q; // [RULE_20]
         default:                    reg_rdata = 16'h0000;
      endcase
   end

   // Overcurrent sequencers, one per channel.
   for (genvar ch = 0; ch < 4; ch++) begin : g_ovc
      aoirq_ovc_retry #(
         .RETRY_PERIOD_CYC (RETRY_PERIOD_CYC),
         .RETRY_ON_CYC     (RETRY_ON_CYC)
      ) u_retry (
         .clk          (clk),
         .rst_n        (rst_n),
         .auto_mode    (!cfg_q[aoirq_pkg::OVC_RESP_BIT]),
         .fault        (overcurrent_det[ch]),
         .host_restart (ien_wr || cfg_wr),
         .amp_on       (amp_on[ch])
      );
   end

   // Configuration outputs toward the analog and serial blocks.
   assign dac_update     = dac_upd_q;
   assign comparators_on = (cmp_mode != aoirq_pkg::CMP_OFF); // [RULE_12]
   assign ext_ref_sel    = cfg_q[aoirq_pkg::REF_SEL_BIT]; // [RULE_13]
   assign frame_bits     = cfg_q[aoirq_pkg::CRC_EN_BIT] ?
                           6'(aoirq_pkg::FRAME_BITS_CRC) :
                           6'(aoirq_pkg::FRAME_BITS_PLAIN); // [RULE_14]
   assign soft_reset_req = sts_q[aoirq_pkg::TMOUT_BIT] &&
                           cfg_q[aoirq_pkg::TMO_RST_BIT];

   // Interrupt pin: low while any enabled flag is set.
   assign int_n = ~|(sts_q & // [RULE_18] [RULE_03] [RULE_04] [RULE_05]
                     ien_q); // [RULE_06] [RULE_07] [RULE_08] [RULE_09]
endmodule : aoirq_top

// File: tb/aoirq_host_model.sv
// Host-side frame source that ends frames and flags bad checksums.
`timescale 1ns/1ps
module aoirq_host_model (
   input  wire logic clk,
   input  wire logic send,
   input  wire logic bad,
   output logic      frame_done    = 1'h0,
   output logic      frame_crc_bad = 1'h0
);
   // Every requested frame ends whole; a bad one also fails its check.
   always @(posedge clk) begin
      frame_done    <= send;
      frame_crc_bad <= send & bad;
   end
endmodule : aoirq_host_model

// File: tb/aoirq_top_sva.sv
// Checker for the interrupt and configuration block ports.
`timescale 1ns/1ps
module aoirq_top_sva (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic        gpio_edge,
   input wire logic [3:0]  data_write,
   input wire logic [3:0]  latch_load_trigger,
   input wire logic        load_pin_n,
   input wire logic [3:0]  dac_update,
   input wire logic        comparators_on,
   input wire logic        ext_ref_sel,
   input wire logic [5:0]  frame_bits,
   input wire logic        int_n
);
   logic [15:0] en_q;
   logic [15:0] cfg_q;
   wire         cw = reg_wr && reg_addr == 4'h3;
   wire  [3:0]  tw = data_write & cfg_q[15:12];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Shadow copies of the two writable registers.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         en_q  <= aoirq_pkg::IRQ_ENABLE_RESET;
         cfg_q <= aoirq_pkg::CONFIG_RESET;
      end else if (reg_wr) begin
         if (reg_addr == 4'h2) en_q <= reg_wdata & 16'hFF1F;
         if (cw) cfg_q <= reg_wdata;
      end
   end
   AST_EXT_REF: assert property (cw |=>
      ext_ref_sel == $past(reg_wdata[8]))
      else $error("reference select does not follow its bit");
   AST_CMP_ON: assert property (cw |=>
      comparators_on == ($past(reg_wdata[11:10]) != 2'h0))
      else $error("comparator power does not follow the mode");
   AST_FRAME: assert property (cw |=>
      frame_bits == ($past(reg_wdata[0]) ? 6'h20 : 6'h18))
      else $error("frame length does not follow checksum enable");
   AST_EN_RSVD: assert property (reg_addr == 4'h2 |->
      reg_rdata[7:5] == 3'h0)
      else $error("reserved enable bits read nonzero");
   AST_CFG_RSVD: assert property (reg_addr == 4'h3 |->
      !reg_rdata[9])
      else $error("reserved config bit reads nonzero");
   AST_INT_PIN: assert property (reg_addr == 4'h1 |->
      int_n == ((reg_rdata & en_q) == 16'h0000))
      else $error("interrupt pin disagrees with enabled flags");
   AST_GPIO_SET: assert property (reg_addr == 4'h1 &&
      $past(gpio_edge) |-> reg_rdata[1])
      else $error("edge flag missing after an edge");
   AST_GPIO_CLR: assert property (reg_addr == 4'h1 &&
      $past(reg_rd && reg_addr == 4'h1 && !gpio_edge) |-> !reg_rdata[1])
      else $error("edge flag survives a clearing read");
   AST_TRANSP: assert property (|tw |=>
      (dac_update & $past(tw)) == $past(tw))
      else $error("transparent channel missed its update");
   AST_LATCH: assert property (|dac_update |-> (dac_update &
      ~$past(tw | latch_load_trigger | {4{!load_pin_n}})) == 4'h0)
      else $error("channel updated without a cause");
   // Main scenarios reached.
   cover property (!int_n);
   cover property (|dac_update);
   cover property (cw && !reg_wdata[0]);
endmodule : aoirq_top_sva
bind aoirq_top aoirq_top_sva i_sva (.*);

// File: tb/tb_aoirq_top.sv
// Self-checking bench for the interrupt and configuration block.
`timescale 1ns/1ps
module tb_aoirq_top;
   logic        clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic        gpio_edge = 1'h0, thermal_shutdown_det = 1'h0;
   logic        thermal_warning_det = 1'h0, hv_supply_low_det = 1'h0;
   logic        load_pin_n = 1'h1, send = 1'h0, bad = 1'h0, int_n;
   logic        frame_done, frame_crc_bad, comparators_on, ext_ref_sel;
   logic        soft_reset_req;
   logic [3:0]  reg_addr = 4'h0, comparator_out = 4'h0, data_write = 4'h0;
   logic [3:0]  overcurrent_det = 4'h0, latch_load_trigger = 4'h0;
   logic [3:0]  dac_update, amp_on;
   logic [5:0]  frame_bits;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   int          miscompares = 0, cmp_count = 0;
   int          bits [13] = '{0, 1, 2, 3, 4, 8, 9, 10, 11, 12, 13, 14, 15};
   aoirq_top #(.TMO_STEP_CYC(20), .RETRY_PERIOD_CYC(16), .RETRY_ON_CYC(4))
      i_dut (.*);
   aoirq_host_model i_host (.*);
   // Free-running 125 MHz clock.
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // Register write and read cycles; a write strobes once, a read strobes once only when c is set.
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(negedge clk);
      reg_wr = 1'h1;
      reg_addr = a;
      reg_wdata = d;
      cyc(1);
      reg_wr = 1'h0;
   endtask : wr
   task automatic rd(logic [3:0] a, logic [15:0] e, logic c);
      @(negedge clk);
      reg_addr = a;
      reg_rd = c;
      #1 chk("rdata", reg_rdata, e);
      cyc(1);
      reg_rd = 1'h0;
   endtask : rd
   // Raises or drops the cause behind one status bit.
   task automatic src(int b, logic v);
      case (b)
         0: begin
            bad = v;
            send = v;
         end
         1: gpio_edge = v;
         2: wr(4'h3, v ? 16'h0005 : 16'h0001);
         3: hv_supply_low_det = v;
         4: thermal_warning_det = v;
         8, 9, 10, 11: overcurrent_det[b-8] = v;
         default: begin
            comparator_out[b-12] = v;
            wr(4'h3, v ? 16'h0C01 : 16'h0001);
         end
      endcase
      cyc(1);
      send = 1'h0;
      gpio_edge = 1'h0;
      cyc(b == 2 ? 45 : 3);
   endtask : src
   task automatic t_reset;
      rd(4'h2, aoirq_pkg::IRQ_ENABLE_RESET, 1'h0);
      rd(4'h3, aoirq_pkg::CONFIG_RESET, 1'h0);
      rd(4'h0, 16'h0000, 1'h0);
      chk("frame_bits", frame_bits, 16'h0020);
      chk("int_n", int_n, 16'h0001);
   endtask : t_reset
   task automatic t_rsvd;
      wr(4'h2, 16'hFFFF);
      rd(4'h2, 16'hFF1F, 1'h0);
      wr(4'h2, 16'h0000);
      wr(4'h3, 16'hFFF0);
      rd(4'h3, 16'hFDF0, 1'h0);
      chk("ext_ref", ext_ref_sel, 16'h0001);
      chk("frame_bits", frame_bits, 16'h0018);
      wr(4'h3, 16'h0001);
      chk("ext_ref", ext_ref_sel, 16'h0000);
   endtask : t_rsvd
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         wr(4'h3, 16'h0001 | 16'(m << 10));
         chk("cmp_on", comparators_on, m != 0);
         comparator_out = 4'h1;
         cyc(3);
         comparator_out = 4'h0;
         cyc(3);
         rd(4'h1, (m == 1 || m == 2) ? 16'h1000 : 16'h0000, 1'h1);
      end
      wr(4'h3, 16'h0001);
   endtask : t_modes
   task automatic t_gate(int b);
      logic [15:0] m;
      m = 16'h0001 << b;
      src(b, 1'h1);
      rd(4'h1, m, 1'h0);
      chk("int_n", int_n, 16'h1);
      wr(4'h2, m);
      chk("int_n", int_n, 16'h0000);
      src(b, 1'h0);
      rd(4'h1, b > 2 ? 16'h0000 : m, 1'h1);
      chk("int_n", int_n, 16'h0001);
      rd(4'h1, 16'h0000, 1'h0);
      wr(4'h2, 16'h0000);
   endtask : t_gate
   task automatic t_flags;
      src(1, 1'h1);
      reg_addr = 4'h1;
      reg_rd = 1'h1;
      gpio_edge = 1'h1;
      cyc(1);
      reg_rd = 1'h0;
      gpio_edge = 1'h0;
      rd(4'h1, 16'h0002, 1'h1);
      wr(4'h3, 16'h0000);
      src(0, 1'h1);
      rd(4'h1, 16'h0000, 1'h0);
      wr(4'h3, 16'h1001);
   endtask : t_flags
   task automatic t_latch;
      data_write = 4'hF;
      cyc(1);
      data_write = 4'h0;
      chk("dac", dac_update, 16'h0001);
      latch_load_trigger = 4'h6;
      cyc(1);
      latch_load_trigger = 4'h0;
      chk("dac", dac_update, 16'h0006);
      load_pin_n = 1'h0;
      cyc(1);
      load_pin_n = 1'h1;
      chk("dac", dac_update, 16'h000E);
   endtask : t_latch
   // Time-out of two steps lands exactly on its end point, then stays quiet once disabled.
   task automatic t_tmo;
      wr(4'h3, 16'h001D);
      cyc(38);
      rd(4'h1, 16'h0000, 1'h0);
      chk("soft_rst", soft_reset_req, 16'h0001);
      rd(4'h1, 16'h0004, 1'h1);
      chk("soft_rst", soft_reset_req, 16'h0000);
      wr(4'h3, 16'h0001);
      cyc(50);
      rd(4'h1, 16'h0000, 1'h0);
   endtask : t_tmo
   // Automatic retry windows, then host mode waiting for a rewrite.
   task automatic t_ovc;
      overcurrent_det = 4'h1;
      cyc(1);
      chk("amp_on", amp_on, 16'h000E);
      cyc(15);
      chk("amp_on", amp_on, 16'h000E);
      cyc(1);
      chk("amp_on", amp_on, 16'h000F);
      cyc(3);
      chk("amp_on", amp_on, 16'h000F);
      cyc(1);
      chk("amp_on", amp_on, 16'h000E);
      overcurrent_det = 4'h0;
      cyc(16);
      chk("amp_on", amp_on, 16'h000F);
      cyc(8);
      chk("amp_on", amp_on, 16'h000F);
      wr(4'h3, 16'h0003);
      overcurrent_det = 4'h2;
      cyc(1);
      overcurrent_det = 4'h0;
      cyc(3);
      chk("amp_on", amp_on, 16'h000D);
      rd(4'h1, 16'h0200, 1'h1);
      wr(4'h2, 16'h0000);
      chk("amp_on", amp_on, 16'h000F);
      wr(4'h3, 16'h0001);
   endtask : t_ovc
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report
   // Main sequence after twelve cycles of reset.
   initial begin
      cyc(12);
      rst_n = 1'h1;
      t_reset;
      t_rsvd;
      t_modes;
      foreach (bits[i]) t_gate(bits[i]);
      t_tmo;
      t_ovc;
      t_flags;
      t_latch;
      final_report;
   end
   // Watchdog cuts a hang short.
   initial begin
      cyc(5000);
      miscompares++;
      final_report;
   end
endmodule : tb_aoirq_top
